// ==== hw/tilc_cfg.svh ====
// Register indices, field positions, reset values of the TX link config bank.
// Assumes it is included by bare name from the register bank and the bench.
`ifndef TILC_CFG_SVH
`define TILC_CFG_SVH

// Register indices; byte address is four times the index
`define TILC_IDX_RECOMB 10'h2AD
`define TILC_IDX_GRP 10'h300
`define TILC_IDX_OFS 10'h310
`define TILC_IDX_LNK 10'h318
`define TILC_IDX_NONIMA 10'h346
`define TILC_IDX_BLK_MASK 10'h3F8

// Group control fields
`define TILC_GRP_RSVD 8
`define TILC_GRP_M_HI 7
`define TILC_GRP_M_LO 6
`define TILC_GRP_ICP_CTC 5
`define TILC_GRP_SCHED_CTC 4
`define TILC_GRP_REF_HI 3
`define TILC_GRP_WIDTH 9

// Link control fields, per byte (link N low byte, link N+8 high byte)
`define TILC_LNK_CNT_USER 7
`define TILC_LNK_USER_EN 6
`define TILC_LNK_NO_COSET 5
`define TILC_LNK_SCRAMBLE 4
`define TILC_LNK_NON_IMA 3
`define TILC_LNK_GRP_HI 2

// Reset values
`define TILC_GRP_RST 9'h0B0
`define TILC_OFS_RST 16'h0000
`define TILC_LNK_RST 16'h0808
`define TILC_NONIMA_RST 16'hFFFF
`define TILC_GRP_CFG_RST {9'h080, 1'h1, 1'h1, 4'h0}
`define TILC_LINK_CFG_RST {8'h00, 1'h0, 1'h0, 1'h1, 1'h0, 1'h1, 3'h0}

`endif

// ==== hw/tilc_pkg.sv ====
// Types of the TX link config bank: decoded group and link settings, bank state.
// Assumes tilc_cfg.svh sits in the include path.
`default_nettype none

package tilc_pkg;

    // Decoded settings of one transmit group
    typedef struct packed {
        logic [8:0] cells_per_frame;
        logic icp_ctc;
        logic sched_ctc;
        logic [3:0] ref_link;
    } tilc_grp_cfg_t;

    // Decoded settings of one link
    typedef struct packed {
        logic [7:0] icp_offset;
        logic count_user_only;
        logic user_tx;
        logic coset_en;
        logic scramble;
        logic non_ima;
        logic [2:0] group;
    } tilc_link_cfg_t;

    // Whole state of the bank
    typedef struct packed {
        logic [7:0][8:0] grp;
        logic [7:0][15:0] ofs;
        logic [7:0][15:0] lnk;
        logic [15:0] non_ima;
        logic [15:0] recomb;
        tilc_grp_cfg_t [7:0] grp_cfg;
        tilc_link_cfg_t [15:0] link_cfg;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } tilc_state_t;

endpackage

`default_nettype wire

// ==== hw/tilc_regs.sv ====
// APB register bank with decoded transmit group and link controls.
// Assumes an APB master on mclk; recombiner flags and PHY enables come from
// logic on the same clock.
//
// Implementation choice: register access over APB.
`include "tilc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module tilc_regs (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output var logic [31:0] prdata,
    output var logic pready,
    output var logic pslverr,
    // Datapath status in
    input wire logic [15:0] recomb_en,
    input wire logic [15:0] phy_user_en,
    // Decoded controls out
    output var tilc_pkg::tilc_grp_cfg_t [7:0] grp_cfg,
    output var tilc_pkg::tilc_link_cfg_t [15:0] link_cfg
);

    tilc_pkg::tilc_state_t state;
    tilc_pkg::tilc_state_t state_next;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] tilc_merge(input logic [15:0] old,
                                               input logic [31:0] wd,
                                               input logic [3:0] st);
        logic [15:0] r;
        r = old;
        if (st[0]) begin
            r[7:0] = wd[7:0];
        end
        if (st[1]) begin
            r[15:8] = wd[15:8];
        end
        return r;
    endfunction

    function automatic logic [8:0] tilc_cells(input logic [1:0] code);
        logic [8:0] c;
        case (code)
            2'h0: c = 9'h020;
            2'h1: c = 9'h040;
            2'h2: c = 9'h080;
            default: c = 9'h100;
        endcase
        return c;
    endfunction

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic [9:0] idx;
    logic [2:0] sub;
    logic aligned;
    logic hit_grp;
    logic hit_ofs;
    logic hit_lnk;
    logic hit_recomb;
    logic hit_nonima;
    logic mapped;
    logic setup;
    logic commit;

    assign idx = paddr[11:2];
    assign sub = paddr[4:2];
    assign aligned = (paddr[1:0] == 2'h0);
    assign hit_grp = aligned && ((idx & `TILC_IDX_BLK_MASK) == `TILC_IDX_GRP);
    assign hit_ofs = aligned && ((idx & `TILC_IDX_BLK_MASK) == `TILC_IDX_OFS);
    assign hit_lnk = aligned && ((idx & `TILC_IDX_BLK_MASK) == `TILC_IDX_LNK);
    assign hit_recomb = aligned && (idx == `TILC_IDX_RECOMB);
    assign hit_nonima = aligned && (idx == `TILC_IDX_NONIMA);
    assign mapped = hit_grp || hit_ofs || hit_lnk || hit_recomb || hit_nonima;
    assign setup = psel && !penable;
    assign commit = psel && penable && state.pready;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [7:0] cb;
        logic [2:0] g;
        logic [8:0] gw;
        logic [15:0] mw;
        cb = 8'h00;
        g = 3'h0;
        gw = 9'h000;
        mw = 16'h0000;
        state_next = state;

        // Status capture
        state_next.recomb = recomb_en;
        for (int k = 0; k < 16; k++) begin
            cb = state.lnk[k % 8][(k / 8) * 8 +: 8];
            state_next.non_ima[k] = cb[`TILC_LNK_NON_IMA];
        end

        // Read answer prepared in the setup cycle; pready rises in access
        state_next.pready = 1'b0;
        if (setup) begin
            state_next.pready = 1'b1;
            state_next.pslverr = !mapped;
            state_next.prdata = 32'h0000_0000;
            if (hit_recomb) begin
                state_next.prdata[15:0] = state.recomb;
            end
            if (hit_grp) begin
                state_next.prdata[8:0] = state.grp[sub];
            end
            if (hit_ofs) begin
                state_next.prdata[15:0] = state.ofs[sub];
            end
            if (hit_lnk) begin
                state_next.prdata[15:0] = state.lnk[sub];
            end
            if (hit_nonima) begin
                state_next.prdata[15:0] = state.non_ima;
            end
        end

        // Writes land on the completing edge; read-only words ignore them
        if (commit && pwrite) begin
            if (hit_grp) begin
                mw = tilc_merge({7'h00, state.grp[sub]}, pwdata, pstrb);
                gw = mw[8:0];
                state_next.grp[sub] = gw;
            end
            if (hit_ofs) begin
                state_next.ofs[sub] = tilc_merge(state.ofs[sub], pwdata, pstrb);
            end
            if (hit_lnk) begin
                state_next.lnk[sub] = tilc_merge(state.lnk[sub], pwdata, pstrb);
            end
        end

        // Group decode
        for (int i = 0; i < 8; i++) begin
            state_next.grp_cfg[i].cells_per_frame =
                tilc_cells(state.grp[i][`TILC_GRP_M_HI:`TILC_GRP_M_LO]);
            state_next.grp_cfg[i].icp_ctc = state.grp[i][`TILC_GRP_ICP_CTC];
            state_next.grp_cfg[i].sched_ctc = state.grp[i][`TILC_GRP_SCHED_CTC];
            state_next.grp_cfg[i].ref_link = state.grp[i][`TILC_GRP_REF_HI:0];
        end

        // Link decode
        for (int k = 0; k < 16; k++) begin
            cb = state.lnk[k % 8][(k / 8) * 8 +: 8];
            g = cb[`TILC_LNK_GRP_HI:0];
            gw = tilc_cells(state.grp[g][`TILC_GRP_M_HI:`TILC_GRP_M_LO]) - 9'h001;
            state_next.link_cfg[k].icp_offset =
                state.ofs[k % 8][(k / 8) * 8 +: 8] & gw[7:0];
            state_next.link_cfg[k].count_user_only = cb[`TILC_LNK_CNT_USER];
            state_next.link_cfg[k].user_tx = cb[`TILC_LNK_NON_IMA] ?
                phy_user_en[k] : cb[`TILC_LNK_USER_EN];
            state_next.link_cfg[k].coset_en = !cb[`TILC_LNK_NO_COSET];
            state_next.link_cfg[k].scramble = cb[`TILC_LNK_SCRAMBLE];
            state_next.link_cfg[k].non_ima = cb[`TILC_LNK_NON_IMA];
            state_next.link_cfg[k].group = g;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state <= '0;
            state.grp <= {8{`TILC_GRP_RST}};
            state.ofs <= {8{`TILC_OFS_RST}};
            state.lnk <= {8{`TILC_LNK_RST}};
            state.non_ima <= `TILC_NONIMA_RST;
            state.grp_cfg <= {8{`TILC_GRP_CFG_RST}};
            state.link_cfg <= {16{`TILC_LINK_CFG_RST}};
        end else begin
            state <= state_next;
        end
    end

    assign prdata = state.prdata;
    assign pready = state.pready;
    assign pslverr = state.pslverr;
    assign grp_cfg = state.grp_cfg;
    assign link_cfg = state.link_cfg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb_main @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    sequence s_rd_setup(logic hit);
        psel && !penable && !pwrite && hit;
    endsequence

    sequence s_wr_commit(logic hit);
        psel && penable && pready && pwrite && hit;
    endsequence

    a_recomb_read: assert property (
        s_rd_setup(hit_recomb) |=> prdata[15:0] == $past(recomb_en, 2))
        else $error("recombiner status read mismatch");

    a_frame_len: assert property (
        grp_cfg[0].cells_per_frame == (9'h020 << $past(state.grp[0][7:6])))
        else $error("frame length decode wrong");

    a_icp_timing: assert property (
        grp_cfg[0].icp_ctc == $past(state.grp[0][5]))
        else $error("ICP timing mode wrong");

    a_sched_timing: assert property (
        grp_cfg[0].sched_ctc == $past(state.grp[0][4]))
        else $error("scheduler timing mode wrong");

    a_ref_link: assert property (
        grp_cfg[0].ref_link == $past(state.grp[0][3:0]))
        else $error("reference link wrong");

    a_offset_width: assert property (
        {1'h0, link_cfg[0].icp_offset} < grp_cfg[link_cfg[0].group].cells_per_frame)
        else $error("offset exceeds frame length");

    a_user_gate: assert property (
        link_cfg[3].user_tx == ($past(state.lnk[3][3]) ? $past(phy_user_en[3])
                                                        : $past(state.lnk[3][6])))
        else $error("user cell gate wrong");

    a_coset_ctl: assert property (
        link_cfg[8].coset_en == !$past(state.lnk[0][13]))
        else $error("coset control wrong");

    a_link_write: assert property (
        s_wr_commit(hit_lnk && sub == 3'h1 && pstrb[1:0] == 2'h3)
        |=> ##1 link_cfg[9].non_ima == $past(pwdata[11], 2))
        else $error("link word write lost");

    a_grp_rsvd_zero: assert property (
        s_rd_setup(hit_grp) |=> prdata[31:9] == 23'h000000 && pready)
        else $error("group unused bits not zero");

    a_nonima_track: assert property (
        state.non_ima[15] == $past(state.lnk[7][11]))
        else $error("non-IMA status does not track mode");

    a_count_low: assert property (
        link_cfg[5].count_user_only == $past(state.lnk[5][7]))
        else $error("cell counter select wrong");

    a_count_high: assert property (
        link_cfg[13].count_user_only == $past(state.lnk[5][15]))
        else $error("upper link counter select wrong");

    a_user_ima: assert property (
        !$past(state.lnk[3][11]) |-> link_cfg[11].user_tx == $past(state.lnk[3][14]))
        else $error("IMA user cell enable wrong");

    a_user_phy: assert property (
        $past(state.lnk[3][11]) |-> link_cfg[11].user_tx == $past(phy_user_en[11]))
        else $error("non-IMA user cell enable wrong");

    a_coset_low: assert property (
        link_cfg[2].coset_en == !$past(state.lnk[2][5]))
        else $error("lower link coset control wrong");

    a_scramble_low: assert property (
        link_cfg[4].scramble == $past(state.lnk[4][4]))
        else $error("lower link scrambling wrong");

    a_scramble_high: assert property (
        link_cfg[12].scramble == $past(state.lnk[4][12]))
        else $error("upper link scrambling wrong");

    a_mode_low: assert property (
        link_cfg[6].non_ima == $past(state.lnk[6][3]))
        else $error("lower link mode wrong");

    a_mode_high: assert property (
        link_cfg[14].non_ima == $past(state.lnk[6][11]))
        else $error("upper link mode wrong");

    a_group_field: assert property (
        link_cfg[15].group == $past(state.lnk[7][10:8]))
        else $error("link group number wrong");

    a_offset_write: assert property (
        s_wr_commit(hit_ofs && sub == 3'h2 && pstrb[1]) |=> state.ofs[2][15:8] == $past(pwdata[15:8]))
        else $error("offset word write lost");

    a_offset_mask: assert property (
        grp_cfg[link_cfg[1].group].cells_per_frame == 9'h020 |-> link_cfg[1].icp_offset[7:5] == 3'h0)
        else $error("offset not cut to five bits");

    a_grp_write: assert property (
        s_wr_commit(hit_grp && sub == 3'h3 && pstrb[0]) |=> state.grp[3][7:0] == $past(pwdata[7:0]))
        else $error("group word write lost");

    a_frame_last: assert property (
        grp_cfg[7].cells_per_frame == (9'h020 << $past(state.grp[7][7:6])))
        else $error("last group frame length wrong");

    a_icp_grp5: assert property (
        grp_cfg[5].icp_ctc == $past(state.grp[5][5]))
        else $error("group five ICP timing wrong");

    a_ref_grp6: assert property (
        grp_cfg[6].ref_link == $past(state.grp[6][3:0]))
        else $error("group six reference link wrong");

    a_nonima_low: assert property (
        state.non_ima[0] == $past(state.lnk[0][3]))
        else $error("link zero non-IMA status wrong");

endmodule // tilc_regs

`default_nettype wire

// ==== bench/tilc_regs_tb_top.sv ====
// Self-checking bench of the TX link config register bank, with a model of the group, offset and link words.
// Assumes tilc_pkg is compiled first and tilc_cfg.svh sits in the include path.
`include "tilc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module tilc_regs_tb_top;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [15:0] recomb_en = 16'h0000;
    logic [15:0] phy_user_en = 16'h0000;
    tilc_pkg::tilc_grp_cfg_t [7:0] grp_cfg;
    tilc_pkg::tilc_link_cfg_t [15:0] link_cfg;
    int error_cnt = 0;
    int total_checks = 0;
    int seed = 64;
    logic [15:0] mdl [3][8];
    logic [31:0] r;
    logic e;

    tilc_regs u_dut (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .recomb_en(recomb_en), .phy_user_en(phy_user_en),
        .grp_cfg(grp_cfg), .link_cfg(link_cfg));

    always #2 mclk = ~mclk;

    // ----------------------------------------
    // Compare and close
    // ----------------------------------------
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_cfg(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // APB master and model
    // ----------------------------------------
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                       output logic [31:0] rd, output logic er);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            error_cnt++;
            test_done();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [11:0] adr(input int k, input int i);
        logic [9:0] b;
        b = (k == 0) ? `TILC_IDX_GRP : (k == 1) ? `TILC_IDX_OFS : `TILC_IDX_LNK;
        return {10'(b + i), 2'b00};
    endfunction

    task automatic wr(input int k, input int i, input logic [31:0] d, input logic [3:0] s);
        logic [15:0] m;
        m = {{8{s[1]}}, {8{s[0]}}};
        apb(1'b1, adr(k, i), d, s, r, e);
        chk_reg({31'h0, e}, 32'h00000000);
        mdl[k][i] = (mdl[k][i] & ~m) | (d[15:0] & m);
        if (k == 0) mdl[0][i] = mdl[0][i] & 16'h01FF;
    endtask

    function automatic logic [15:0] stat();
        logic [15:0] v;
        for (int i = 0; i < 8; i++) begin
            v[i] = mdl[2][i][3];
            v[i + 8] = mdl[2][i][11];
        end
        return v;
    endfunction

    function automatic logic [15:0] exp_link(input int n);
        logic [7:0] w;
        logic [7:0] o;
        logic [1:0] m;
        w = mdl[2][n % 8][(n / 8) * 8 +: 8];
        o = mdl[1][n % 8][(n / 8) * 8 +: 8];
        m = mdl[0][w[2:0]][7:6];
        o = o & 8'((32 << m) - 1);
        return {o, w[7], w[3] ? phy_user_en[n] : w[6], ~w[5], w[4], w[3], w[2:0]};
    endfunction

    // ----------------------------------------
    // Full comparison of words and decoded outputs
    // ----------------------------------------
    task automatic check_all;
        logic [8:0] g;
        repeat (4) @(posedge mclk);
        for (int k = 0; k < 3; k++) begin
            for (int i = 0; i < 8; i++) begin
                apb(1'b0, adr(k, i), 32'h00000000, 4'h0, r, e);
                chk_reg(r, {16'h0000, mdl[k][i]});
            end
        end
        apb(1'b0, {`TILC_IDX_NONIMA, 2'b00}, 32'h00000000, 4'h0, r, e);
        chk_reg(r, {16'h0000, stat()});
        apb(1'b0, {`TILC_IDX_RECOMB, 2'b00}, 32'h00000000, 4'h0, r, e);
        chk_reg(r, {16'h0000, recomb_en});
        for (int i = 0; i < 8; i++) begin
            g = mdl[0][i][8:0];
            chk_cfg({1'b0, grp_cfg[i]}, {1'b0, 9'(32 << g[7:6]), g[5], g[4], g[3:0]});
        end
        for (int n = 0; n < 16; n++) begin
            chk_cfg(link_cfg[n], exp_link(n));
        end
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        logic [31:0] nw;
        for (int i = 0; i < 8; i++) begin
            mdl[0][i] = 16'h00B0;
            mdl[1][i] = 16'h0000;
            mdl[2][i] = 16'h0808;
        end
        repeat (3) @(posedge mclk);
        rst_b <= 1'b1;
        recomb_en <= 16'($random(seed));
        phy_user_en <= 16'($random(seed));
        check_all();
        $display("test 0 done");
        for (int t = 1; t < 4; t++) begin
            for (int i = 0; i < 8; i++) begin
                // Reserved group bit kept at zero by the host
                wr(0, i, $random(seed) & 32'hFFFFFEFF, 4'hF);
                wr(1, i, $random(seed), (t == 3) ? 4'h1 : 4'hF);
                nw = $random(seed);
                // Leave IMA first, change group only once non-IMA is reported
                wr(2, i, {16'h0000, mdl[2][i] | 16'h0808}, 4'hF);
                r = 32'h00000000;
                for (int n = 0; n < 10 && (r[i] !== 1'b1 || r[i + 8] !== 1'b1); n++) begin
                    apb(1'b0, {`TILC_IDX_NONIMA, 2'b00}, 32'h00000000, 4'h0, r, e);
                end
                if (r[i] !== 1'b1 || r[i + 8] !== 1'b1) begin
                    error_cnt++;
                    test_done();
                end
                wr(2, i, nw | 32'h00000808, 4'hF);
                wr(2, i, nw, (t == 3) ? 4'h2 : 4'hF);
            end
            recomb_en <= 16'($random(seed));
            phy_user_en <= 16'($random(seed));
            check_all();
            $display("test %0d done", t);
        end
        // Status word ignores writes, unmapped and misaligned places are refused
        apb(1'b1, {`TILC_IDX_NONIMA, 2'b00}, ~{16'h0000, stat()}, 4'hF, r, e);
        chk_reg({31'h0, e}, 32'h00000000);
        apb(1'b0, 12'hFFC, 32'h00000000, 4'h0, r, e);
        chk_reg({31'h0, e}, 32'h00000001);
        chk_reg(r, 32'h00000000);
        apb(1'b1, adr(1, 0) | 12'h002, 32'h0000FFFF, 4'hF, r, e);
        chk_reg({31'h0, e}, 32'h00000001);
        check_all();
        $display("test 4 done");
        test_done();
    end
endmodule // tilc_regs_tb_top

`default_nettype wire
